/* File: verilog/pipe_ctrl_cfg.svh */
`ifndef PIPE_CTRL_CFG_SVH
`define PIPE_CTRL_CFG_SVH

// ------------------------------------------------------------
// Addresses
// ------------------------------------------------------------
`define RESET_PC          32'h0000_0000
`define PC_STEP           32'h0000_0004
`define REG_ZERO          5'h00

// ------------------------------------------------------------
// Multiplier configurations
// ------------------------------------------------------------
`define MUL_NONE          0
`define MUL_EMBEDDED      1
`define MUL_LOGIC         2

// ------------------------------------------------------------
// Cycle counts, whole instruction time
// ------------------------------------------------------------
`define SHIFT_EMB_CYCLES  7'h03
`define SHIFT_LE_CYCLES   7'h04
`define SHIFT_SER_BASE    7'h01
`define MUL_EMB_CYCLES    7'h03
`define MUL_LE_CYCLES     7'h0B
`define DIV_BASE_CYCLES   7'h02

`endif

/* File: verilog/pipe_pkg.sv */
package pipe_pkg;

	typedef enum logic [3:0] {
		cls_alu        = 4'h0,
		cls_cust_comb  = 4'h1,
		cls_cust_multi = 4'h2,
		cls_rdctl      = 4'h3,
		cls_branch     = 4'h4,
		cls_jump       = 4'h5,
		cls_flush      = 4'h6,
		cls_cache      = 4'h7,
		cls_load       = 4'h8,
		cls_store      = 4'h9,
		cls_mul        = 4'hA,
		cls_div        = 4'hB,
		cls_shift      = 4'hC
	} insn_class_e;

	typedef enum logic [1:0] {
		mc_shift = 2'h0,
		mc_mul   = 2'h1,
		mc_div   = 2'h2
	} mc_op_e;

	typedef struct packed {
		logic        req;
		logic        have;
		logic        drop;
		logic [31:0] pc;
		logic [31:0] redir;
		logic [31:0] insn;
	} fetch_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
		logic [31:0] insn;
	} dec_s;

	typedef struct packed {
		logic        valid;
		insn_class_e cls;
		logic [4:0]  dst;
		logic        wr;
		logic [31:0] pc;
		logic        pred;
		logic [31:0] alt;
	} exe_s;

	typedef struct packed {
		logic        valid;
		insn_class_e cls;
		logic [4:0]  dst;
		logic        wr;
		logic        mispred;
		logic [31:0] target;
		logic        bus;
	} mem_s;

	typedef struct packed {
		logic       valid;
		logic [4:0] dst;
		logic       wr;
	} wb_s;

	typedef struct packed {
		fetch_s f;
		dec_s   d;
		exe_s   e;
		mem_s   m;
		wb_s    w;
	} pipe_s;

	typedef struct packed {
		logic [6:0] cnt;
	} mc_s;

endpackage

/* File: verilog/ctl_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface ctl_if;
	logic                 start;
	pipe_pkg::mc_op_e     op;
	logic [4:0]           shamt;
	logic [5:0]           div_bits;
	logic                 busy;
	logic                 is_branch;
	logic [31:0]          pc;
	logic [31:0]          offset;
	logic                 take;
	logic [31:0]          take_pc;
	logic [31:0]          alt_pc;

	modport ctl (output start, op, shamt, div_bits, is_branch, pc, offset,
		input busy, take, take_pc, alt_pc);
	modport mc (input start, op, shamt, div_bits, output busy);
	modport bp (input is_branch, pc, offset, output take, take_pc, alt_pc);
endinterface

`default_nettype wire

/* File: verilog/multicycle_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctrl_cfg.svh"

module multicycle_unit #(
	parameter int MUL_KIND = `MUL_EMBEDDED
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Control side
	ctl_if.mc         ctl
);

	if (MUL_KIND < `MUL_NONE || MUL_KIND > `MUL_LOGIC) begin : g_bad_kind
		$error("multiplier kind out of range");
	end

	pipe_pkg::mc_s st;
	pipe_pkg::mc_s next_st;
	logic [6:0]    total;

	// ------------------------------------------------------------
	// Whole instruction time per operation
	// ------------------------------------------------------------
	always_comb begin
		total = 7'h01;
		unique case (ctl.op)
			pipe_pkg::mc_shift: begin
				if (MUL_KIND == `MUL_NONE)
					total = `SHIFT_SER_BASE + {2'h0, ctl.shamt};
				else if (MUL_KIND == `MUL_EMBEDDED)
					total = `SHIFT_EMB_CYCLES;
				else
					total = `SHIFT_LE_CYCLES;
			end
			pipe_pkg::mc_mul: begin
				if (MUL_KIND == `MUL_LOGIC)
					total = `MUL_LE_CYCLES;
				else
					total = `MUL_EMB_CYCLES;
			end
			pipe_pkg::mc_div: begin
				total = `DIV_BASE_CYCLES + {ctl.div_bits, 1'b0};
			end
			default: total = 7'h01;
		endcase
	end

	// ------------------------------------------------------------
	// Residual stall counter
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (ctl.start)
			next_st.cnt = total - 7'h01;
		else if (st.cnt != 7'h00)
			next_st.cnt = st.cnt - 7'h01;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign ctl.busy = (st.cnt != 7'h00);

endmodule

`default_nettype wire

/* File: verilog/branch_predict.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctrl_cfg.svh"

module branch_predict (
	// Decode side
	ctl_if.bp bp
);

	// ------------------------------------------------------------
	// Backward taken, forward not taken
	// ------------------------------------------------------------
	logic [31:0] target;
	logic [31:0] fall;

	assign target     = bp.pc + bp.offset;
	assign fall       = bp.pc + `PC_STEP;
	assign bp.take    = bp.is_branch & bp.offset[31];
	// Target for a taken guess, then the address to use if the guess proves wrong
	assign bp.take_pc = target;
	assign bp.alt_pc  = bp.offset[31] ? fall : target;

endmodule

`default_nettype wire

/* File: verilog/pipeline_control.sv */

`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctrl_cfg.svh"

module pipeline_control #(
	parameter int MUL_KIND = `MUL_EMBEDDED
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	// Instruction bus
	output logic                         ibus_read,
	output logic [31:0]                  ibus_address,
	input  wire logic                    ibus_waitrequest,
	input  wire logic [31:0]             ibus_readdata,
	// Decoder
	output logic [31:0]                  dec_insn,
	output logic [31:0]                  dec_pc,
	input  wire pipe_pkg::insn_class_e   dec_class,
	input  wire logic [4:0]              dec_dst,
	input  wire logic                    dec_wr,
	input  wire logic [4:0]              dec_src_a,
	input  wire logic [4:0]              dec_src_b,
	input  wire logic                    dec_use_a,
	input  wire logic                    dec_use_b,
	input  wire logic [31:0]             dec_offset,
	// Execute datapath
	output logic                         exe_valid,
	output logic [31:0]                  exe_pc,
	input  wire logic                    exe_taken,
	input  wire logic [31:0]             exe_target,
	input  wire logic [4:0]              exe_shamt,
	input  wire logic [5:0]              exe_div_bits,
	// Data bus and custom unit
	output logic                         dbus_read,
	output logic                         dbus_write,
	input  wire logic                    dbus_waitrequest,
	output logic                         ci_active,
	input  wire logic                    ci_stall,
	// Writeback
	output logic                         wb_valid,
	output logic [4:0]                   wb_dst,
	output logic                         wb_wr,
	// Status
	output logic                         stall,
	output logic                         flush
);

	if (MUL_KIND < `MUL_NONE || MUL_KIND > `MUL_LOGIC) begin : g_bad_kind
		$error("multiplier kind out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	pipe_pkg::pipe_s st;
	pipe_pkg::pipe_s next_st;

	ctl_if ctl ();

	logic        m_mc;
	logic        m_mem;
	logic        stall_bus;
	logic        stall_mc;
	logic        stall_ci;
	logic        m_flush_cls;
	logic        hazard;
	logic        move_de;
	logic        move_em;
	logic        pred_redirect;
	logic        f_done;
	logic        f_ready;
	logic [31:0] f_word;
	logic        d_free;
	logic        f_take;
	logic        redirect;
	logic [31:0] redirect_pc;

	// ------------------------------------------------------------
	// Class helpers
	// ------------------------------------------------------------
	function automatic logic long_lat(input pipe_pkg::insn_class_e c);
		long_lat = (c == pipe_pkg::cls_load) || (c == pipe_pkg::cls_mul) ||
			(c == pipe_pkg::cls_div) || (c == pipe_pkg::cls_shift) ||
			(c == pipe_pkg::cls_cust_multi);
	endfunction

	function automatic logic is_mc(input pipe_pkg::insn_class_e c);
		is_mc = (c == pipe_pkg::cls_mul) || (c == pipe_pkg::cls_div) ||
			(c == pipe_pkg::cls_shift);
	endfunction

	function automatic logic uses_bus(input pipe_pkg::insn_class_e c);
		uses_bus = (c == pipe_pkg::cls_load) || (c == pipe_pkg::cls_store);
	endfunction

	function automatic logic reads_reg(input logic [4:0] r);
		reads_reg = (r != `REG_ZERO) &&
			((dec_use_a && dec_src_a == r) || (dec_use_b && dec_src_b == r));
	endfunction

	// ------------------------------------------------------------
	// Memory stage stall sources
	// ------------------------------------------------------------
	assign m_mem     = st.m.valid & uses_bus(st.m.cls);
	assign m_mc      = st.m.valid & is_mc(st.m.cls);
	assign stall_bus = m_mem & st.m.bus & dbus_waitrequest;
	assign stall_mc  = m_mc & ctl.busy;
	assign stall_ci  = st.m.valid & (st.m.cls == pipe_pkg::cls_cust_multi) &
		ci_stall;
	// Single-cycle classes match none of these sources, so they never stall
	assign stall     = stall_bus | stall_mc | stall_ci;

	// ------------------------------------------------------------
	// Flush decision, resolved as the instruction leaves memory
	// ------------------------------------------------------------
	// Resolving here means F, D and E hold exactly the three victims
	always_comb begin
		m_flush_cls = 1'b0;
		unique case (st.m.cls)
			pipe_pkg::cls_jump:   m_flush_cls = 1'b1;
			pipe_pkg::cls_flush:  m_flush_cls = 1'b1;
			pipe_pkg::cls_cache:  m_flush_cls = 1'b1;
			pipe_pkg::cls_branch: m_flush_cls = st.m.mispred;
			default:              m_flush_cls = 1'b0;
		endcase
	end

	assign flush = st.m.valid & ~stall & m_flush_cls;

	// ------------------------------------------------------------
	// Decode interlock and stage moves
	// ------------------------------------------------------------
	assign hazard = st.d.valid & (
		(st.e.valid & st.e.wr & long_lat(st.e.cls) & reads_reg(st.e.dst)) |
		(st.m.valid & st.m.wr & long_lat(st.m.cls) & reads_reg(st.m.dst))
	);

	assign move_de       = ~stall & ~flush & st.d.valid & ~hazard;
	assign move_em       = ~stall & ~flush & st.e.valid;
	assign pred_redirect = move_de & ctl.take;
	assign redirect      = flush | pred_redirect;
	assign redirect_pc   = flush ? st.m.target : ctl.take_pc;

	// ------------------------------------------------------------
	// Fetch availability
	// ------------------------------------------------------------
	assign f_done  = st.f.req & ~ibus_waitrequest;
	assign f_ready = st.f.have | (f_done & ~st.f.drop);
	assign f_word  = st.f.have ? st.f.insn : ibus_readdata;
	// Empty decode slot may only be refilled while nothing stalls
	assign d_free  = ~stall & (~st.d.valid | move_de);
	assign f_take  = d_free & ~redirect & f_ready;

	// ------------------------------------------------------------
	// Helper units
	// ------------------------------------------------------------
	assign ctl.is_branch = st.d.valid & (dec_class == pipe_pkg::cls_branch);
	assign ctl.pc        = st.d.pc;
	assign ctl.offset    = dec_offset;
	assign ctl.start     = move_em & is_mc(st.e.cls);
	assign ctl.shamt     = exe_shamt;
	assign ctl.div_bits  = exe_div_bits;

	always_comb begin
		ctl.op = pipe_pkg::mc_shift;
		if (st.e.cls == pipe_pkg::cls_mul)
			ctl.op = pipe_pkg::mc_mul;
		else if (st.e.cls == pipe_pkg::cls_div)
			ctl.op = pipe_pkg::mc_div;
	end

	multicycle_unit #(
		.MUL_KIND (MUL_KIND)
	) u_mc (
		.clk    (clk),
		.arst_n (arst_n),
		.ctl    (ctl.mc)
	);

	branch_predict u_bp (
		.bp (ctl.bp)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Fetch: an open bus read always runs to completion
		if (f_done) begin
			next_st.f.req = 1'b0;
			if (st.f.drop) begin
				next_st.f.drop = 1'b0;
				next_st.f.pc   = st.f.redir;
				next_st.f.req  = 1'b1;
			end else begin
				next_st.f.have = 1'b1;
				next_st.f.insn = ibus_readdata;
			end
		end
		if (f_take) begin
			next_st.f.have = 1'b0;
			next_st.f.pc   = st.f.pc + `PC_STEP;
			next_st.f.req  = 1'b1;
		end
		if (redirect) begin
			next_st.f.have = 1'b0;
			if (st.f.req & ibus_waitrequest) begin
				// Wrong-path read still open: finish and discard it
				next_st.f.drop  = 1'b1;
				next_st.f.redir = redirect_pc;
			end else begin
				next_st.f.drop = 1'b0;
				next_st.f.pc   = redirect_pc;
				next_st.f.req  = 1'b1;
			end
		end

		// Decode
		if (!stall) begin
			if (flush || pred_redirect)
				next_st.d.valid = 1'b0;
			else if (f_take) begin
				next_st.d.valid = 1'b1;
				next_st.d.pc    = st.f.pc;
				next_st.d.insn  = f_word;
			end else if (move_de)
				next_st.d.valid = 1'b0;
		end

		// Execute
		if (!stall) begin
			next_st.e.valid = move_de;
			if (move_de) begin
				next_st.e.cls  = dec_class;
				next_st.e.dst  = dec_dst;
				next_st.e.wr   = dec_wr;
				next_st.e.pc   = st.d.pc;
				next_st.e.pred = ctl.take;
				next_st.e.alt  = ctl.alt_pc;
			end
		end

		// Memory
		if (!stall) begin
			next_st.m.valid = move_em;
			if (move_em) begin
				next_st.m.cls     = st.e.cls;
				next_st.m.dst     = st.e.dst;
				next_st.m.wr      = st.e.wr;
				next_st.m.mispred = (st.e.cls == pipe_pkg::cls_branch) &&
					(exe_taken != st.e.pred);
				next_st.m.target  = (st.e.cls == pipe_pkg::cls_branch) ?
					st.e.alt : exe_target;
				next_st.m.bus     = uses_bus(st.e.cls);
			end
		end else if (st.m.bus && !dbus_waitrequest)
			next_st.m.bus = 1'b0;

		// Writeback: retires the memory instruction once it leaves
		next_st.w.valid = st.m.valid & ~stall;
		next_st.w.dst   = st.m.dst;
		next_st.w.wr    = st.m.wr & st.m.valid & ~stall;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st          <= '0;
			st.f.req    <= 1'b1;
			st.f.pc     <= `RESET_PC;
		end else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign ibus_read    = st.f.req;
	assign ibus_address = st.f.pc;
	assign dec_insn     = st.d.insn;
	assign dec_pc       = st.d.pc;
	assign exe_valid    = st.e.valid;
	assign exe_pc       = st.e.pc;
	assign dbus_read    = m_mem & st.m.bus & (st.m.cls == pipe_pkg::cls_load);
	assign dbus_write   = m_mem & st.m.bus & (st.m.cls == pipe_pkg::cls_store);
	assign ci_active    = st.m.valid & (st.m.cls == pipe_pkg::cls_cust_multi);
	assign wb_valid     = st.w.valid;
	assign wb_dst       = st.w.dst;
	assign wb_wr        = st.w.wr;

endmodule

`default_nettype wire

/* File: test/pipe_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module pipe_ctrl_asserts #(
	parameter int MUL_KIND = 1
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Buses and custom unit
	input wire logic        ibus_read,
	input wire logic [31:0] ibus_address,
	input wire logic        ibus_waitrequest,
	input wire logic        dbus_read,
	input wire logic        dbus_write,
	input wire logic        dbus_waitrequest,
	input wire logic        ci_active,
	input wire logic        ci_stall,
	// Pipeline
	input wire logic [31:0] dec_pc,
	input wire logic        exe_valid,
	input wire logic [31:0] exe_pc,
	input wire logic        wb_valid,
	input wire logic        stall,
	input wire logic        flush
);
	// --------------------------------------------------
	// Properties
	// --------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	data_wait_stall_a: assert property (
		(dbus_read || dbus_write) && dbus_waitrequest |-> stall)
		else $error("data bus wait without stall");
	data_req_hold_a: assert property (
		(dbus_read || dbus_write) && dbus_waitrequest
		|=> $stable({dbus_read, dbus_write}))
		else $error("data request dropped before completion");
	fetch_hold_a: assert property (
		ibus_read && ibus_waitrequest |=> ibus_read && $stable(ibus_address))
		else $error("fetch request moved while waiting");
	custom_stall_a: assert property (
		ci_active && ci_stall |-> stall)
		else $error("custom unit stall ignored");
	decode_freeze_a: assert property (
		stall |=> $stable(dec_pc))
		else $error("decode loaded during stall");
	exe_freeze_a: assert property (
		stall |=> $stable(exe_valid) && $stable(exe_pc))
		else $error("execute slot changed during stall");
	stall_bubble_a: assert property (
		stall |=> !wb_valid)
		else $error("retire while memory stage stalled");
	flush_cancel_a: assert property (
		flush |=> wb_valid ##1 !wb_valid [*3])
		else $error("cancelled work retired after flush");
	flush_gap_a: assert property (
		flush |=> !flush [*3])
		else $error("flush raised again too soon");
endmodule

bind pipeline_control pipe_ctrl_asserts #(.MUL_KIND(MUL_KIND)) u_chk (
	.clk, .arst_n, .ibus_read, .ibus_address, .ibus_waitrequest,
	.dbus_read, .dbus_write, .dbus_waitrequest, .ci_active, .ci_stall,
	.dec_pc, .exe_valid, .exe_pc, .wb_valid, .stall, .flush
);

`default_nettype wire

/* File: test/bus_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
	// Clock and mode
	input  wire logic        clk,
	input  wire logic        slow,
	// Instruction bus
	input  wire logic        ibus_read,
	input  wire logic [31:0] ibus_address,
	output var  logic        ibus_waitrequest,
	output var  logic [31:0] ibus_readdata,
	// Data bus
	input  wire logic        dbus_read,
	input  wire logic        dbus_write,
	output var  logic        dbus_waitrequest
);
	// --------------------------------------------------
	// Program store and waits
	// --------------------------------------------------
	logic [31:0] rom [128];
	logic        hold;

	initial begin
		ibus_waitrequest = 1'b0;
		ibus_readdata = 32'h0;
		dbus_waitrequest = 1'b0;
	end

	// Word is garbage while waiting, so a early capture shows up
	always @(negedge clk) begin
		hold = slow && ($urandom_range(2, 0) == 0);
		ibus_waitrequest <= hold;
		ibus_readdata <= (hold || !ibus_read) ? ~ibus_readdata
			: rom[ibus_address[8:2]];
		dbus_waitrequest <= slow && (dbus_read || dbus_write)
			&& ($urandom_range(1, 0) == 0);
	end
endmodule

`default_nettype wire

/* File: test/five_stage_pipeline_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module five_stage_pipeline_control_tb;
	// --------------------------------------------------
	// Signals
	// --------------------------------------------------
	localparam logic [31:0] TARGET = 32'h0000_0100;
	logic                  clk = 1'b0;
	logic                  arst_n = 1'b0;
	logic                  slow = 1'b0;
	logic                  running = 1'b0;
	logic                  exe_taken = 1'b0;
	logic                  dec_wr = 1'b0;
	logic                  dec_use = 1'b0;
	logic                  ci_stall = 1'b0;
	logic [4:0]            dec_dst = 5'h00;
	logic [4:0]            dec_src_a = 5'h00;
	logic [4:0]            dec_src_b = 5'h00;
	logic [4:0]            exe_shamt = 5'h00;
	logic [5:0]            exe_div_bits = 6'h01;
	logic [31:0]           dec_offset = 32'h0;
	pipe_pkg::insn_class_e dec_class = pipe_pkg::cls_alu;
	logic ibus_read, ibus_waitrequest, exe_valid, dbus_read, dbus_write;
	logic dbus_waitrequest, ci_active, wb_valid, wb_wr, stall, flush;
	logic [31:0] ibus_address, ibus_readdata, dec_insn, dec_pc, exe_pc;
	logic [4:0]  wb_dst;
	logic [31:0] exp_pc, pw, pw2, w, w2;
	int          fails, check_count, ci_n, retired, last_t, cyc, g, h, px;

	pipeline_control #(.MUL_KIND(1)) uut (
		.clk, .arst_n, .ibus_read, .ibus_address, .ibus_waitrequest,
		.ibus_readdata, .dec_insn, .dec_pc, .dec_class, .dec_dst, .dec_wr,
		.dec_src_a, .dec_src_b, .dec_use_a(dec_use), .dec_use_b(dec_use),
		.dec_offset, .exe_valid, .exe_pc, .exe_taken, .exe_target(TARGET),
		.exe_shamt, .exe_div_bits, .dbus_read, .dbus_write,
		.dbus_waitrequest, .ci_active, .ci_stall, .wb_valid, .wb_dst,
		.wb_wr, .stall, .flush
	);

	bus_slave_model u_mem (
		.clk, .slow, .ibus_read, .ibus_address, .ibus_waitrequest,
		.ibus_readdata, .dbus_read, .dbus_write, .dbus_waitrequest
	);

	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	// --------------------------------------------------
	// Expectations
	// --------------------------------------------------
	function automatic logic [31:0] word(input logic [31:0] pc);
		return u_mem.rom[pc[8:2]];
	endfunction

	function automatic logic [31:0] mk(input logic [3:0] c,
		input logic [4:0] d, a, input logic u, t, input logic [3:0] o);
		return {{6{o[3]}}, o, t, u, 5'h00, a, 1'b1, d, c};
	endfunction

	function automatic logic [31:0] rand_word();
		logic [3:0] c;
		logic [4:0] d;
		c = 4'($urandom_range(12, 0));
		d = 5'($urandom_range(31, 1));
		return mk(c, d, 5'($urandom), 1'b0, 1'($urandom),
			4'($urandom_range(15, 1)));
	endfunction

	// Own cycles, or penalty paid by the next instruction when post
	function automatic int cyc_of(input logic [31:0] v, input logic post);
		case (v[3:0])
			4'h2, 4'hA, 4'hC: return post ? 0 : 3;
			4'hB: return post ? 0 : 4 + 2 * int'(v[8:4]);
			4'h4: return !post ? 1 : v[31] != v[21] ? 3 : int'(v[31]);
			4'h5, 4'h6, 4'h7: return post ? 3 : 1;
			default: return post ? 0 : 1;
		endcase
	endfunction

	function automatic logic [31:0] next_pc(input logic [31:0] v, pc);
		if (v[3:0] == 4'h4 && v[21])
			return pc + {{20{v[31]}}, v[31:22], 2'b00};
		if (v[3:0] inside {4'h5, 4'h6, 4'h7})
			return TARGET;
		return pc + 32'h4;
	endfunction

	function automatic int haz(input logic [31:0] p, c);
		if (!(p[3:0] inside {4'h2, 4'h8, 4'hA, 4'hB, 4'hC}) || !c[20])
			return 0;
		return (c[14:10] == p[8:4]) ? 1 : 0;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// --------------------------------------------------
	// Decoder, datapath and retire monitor
	// --------------------------------------------------
	always @(negedge clk) begin
		w2 = word(exe_pc);
		dec_class <= pipe_pkg::insn_class_e'(dec_insn[3:0]);
		dec_dst <= dec_insn[8:4];
		dec_wr <= dec_insn[9];
		dec_src_a <= dec_insn[14:10];
		dec_src_b <= dec_insn[19:15];
		dec_use <= dec_insn[20];
		dec_offset <= {{20{dec_insn[31]}}, dec_insn[31:22], 2'b00};
		exe_taken <= w2[21];
		exe_shamt <= w2[14:10];
		exe_div_bits <= {1'b0, w2[8:4]} + 6'h01;
		ci_stall <= ci_active && ci_n < 2;
		// Restart per instruction so back-to-back custom ops both stall
		ci_n <= (ci_active && ci_n < 2) ? ci_n + 1 : 0;
	end

	always @(negedge clk) begin
		if (running && wb_valid === 1'b1) begin
			w = word(exp_pc);
			check("wb_dst", {27'h0, wb_dst}, {27'h0, w[8:4]});
			check("wb_wr", {31'h0, wb_wr}, {31'h0, w[9]});
			// Decode waits while producer sits in E or in M
			h = (haz(pw, w) != 0) ? 2 : ((haz(pw2, w) != 0 &&
				cyc_of(pw, 1'b1) == 0 && px == 0) ? 1 : 0);
			g = cyc_of(w, 1'b0) + cyc_of(pw, 1'b1) + h;
			if (!slow && retired > 0)
				check("gap", 32'(cyc - last_t), 32'(g));
			last_t = cyc;
			pw2 = pw;
			px = h;
			pw = w;
			exp_pc = next_pc(w, exp_pc);
			retired++;
		end
	end

	// --------------------------------------------------
	// Tests
	// --------------------------------------------------
	task automatic run_test(input string name, input int n, input logic fast);
		running = 1'b0;
		arst_n <= 1'b0;
		slow <= !fast;
		repeat (16) @(negedge clk);
		check("reset_fetch", {31'h0, ibus_read}, 32'h1);
		check("reset_retire", {31'h0, wb_valid}, 32'h0);
		exp_pc = 32'h0;
		pw = 32'h0;
		pw2 = 32'h0;
		px = 0;
		retired = 0;
		running = 1'b1;
		arst_n <= 1'b1;
		for (int t = 0; t < 6000 && retired < n; t++)
			@(negedge clk);
		running = 1'b0;
		check("retired", {31'h0, retired >= n}, 32'h1);
		$display("test %s done", name);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Span covers three tests at their cycle limit
	initial begin
		#1000000;
		fails++;
		stop_test();
	end

	initial begin
		void'($urandom(40805));
		for (int i = 0; i < 128; i++)
			u_mem.rom[i] = 32'h0;
		u_mem.rom[0] = mk(4'h8, 5'h05, 5'h00, 1'b0, 1'b0, 4'h1);
		u_mem.rom[1] = mk(4'h0, 5'h06, 5'h05, 1'b1, 1'b0, 4'h1);
		u_mem.rom[2] = mk(4'h5, 5'h07, 5'h00, 1'b0, 1'b0, 4'h1);
		u_mem.rom[64] = mk(4'hB, 5'h1F, 5'h00, 1'b0, 1'b0, 4'h1);
		u_mem.rom[65] = mk(4'hB, 5'h01, 5'h00, 1'b0, 1'b0, 4'h1);
		u_mem.rom[66] = mk(4'h4, 5'h02, 5'h00, 1'b0, 1'b1, 4'h2);
		u_mem.rom[68] = mk(4'h4, 5'h03, 5'h00, 1'b0, 1'b0, 4'hE);
		u_mem.rom[69] = mk(4'h4, 5'h04, 5'h00, 1'b0, 1'b1, 4'hF);
		run_test("corner", 14, 1'b1);
		for (int i = 0; i < 128; i++)
			u_mem.rom[i] = rand_word();
		run_test("random_fast", 300, 1'b1);
		run_test("random_slow", 300, 1'b0);
		stop_test();
	end
endmodule

`default_nettype wire
